// file: hw/ubrg_top.sv
// baud rate generator with clock select, oversampling and wishbone registers
// Overview of operation
// - source select: peripheral, fixed eighth, programmable, pin
// - selected clock divided by 16-bit divisor
// - zero divisor yields no clock
// - divisor one passes selected clock through
// - asynchronous: sampling then divide by eight/sixteen
// - fraction adds eighth steps to divisor
// - fraction stretches high phase occasionally
// - channel clock stopped unless operating mode one
// - interrupt shared only in operating mode one
// - clock requests during partial wakeup
// - synchronous: bit clock without oversampling
`timescale 1ns/1ps
`include "ubrg_defs.svh"
module ubrg_top #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // clock sources from outside
  input  wire logic        pck_i,
  input  wire logic        sck_i,
  // serial clock pin drive
  output logic             sck_o,
  output logic             sck_oe_o,
  // receive line for wakeup
  input  wire logic        rxd_i,
  // channel interrupt and power manager
  input  wire logic        chan_irq_i,
  output logic             irq_o,
  output logic             clk_req_o,
  // enables to receiver and transmitter
  output logic             samp_en_o,
  output logic             baud_en_o,
  output logic             samp_clk_o
);
  import ubrg_pkg::*;

  // ********************************
  // register file
  // ********************************
  logic [31:0] wmr_ff;
  logic [31:0] cmr_ff;
  logic [31:0] bdr_ff;
  logic [31:0] rdat_ff;
  logic        ack_ff;
  logic [7:0]  bcnt_ff;

  // bus decode
  wire         req_w   = cyc_i && stb_i && !ack_ff;
  wire         wr_w    = cyc_i && stb_i && we_i && ack_ff; // write lands on the acknowledged edge
  wire         hit_wmr = (adr_i == `UBRG_OFS_WMR);
  wire         hit_cmr = (adr_i == `UBRG_OFS_CMR);
  wire         hit_bdr = (adr_i == `UBRG_OFS_BDR);
  wire         hit_str = (adr_i == `UBRG_OFS_STR);
  wire  [31:0] bmask_w = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // byte-lane merge of each register
  wire  [31:0] nxt_wmr = ((wmr_ff & ~bmask_w) | (dat_i & bmask_w)) & `UBRG_WMR_MASK;
  wire  [31:0] nxt_cmr = ((cmr_ff & ~bmask_w) | (dat_i & bmask_w)) & `UBRG_CMR_MASK;
  wire  [31:0] nxt_bdr = ((bdr_ff & ~bmask_w) | (dat_i & bmask_w)) & `UBRG_BDR_MASK;

  // field views
  wire  [1:0]  opm_w  = wmr_ff[1:0];
  wire         run_en = (opm_w == `UBRG_OPM_CHAN);
  wire  ubrg_src_type css_w = ubrg_src_type'(cmr_ff[`UBRG_CMR_CSS_LSB +: 2]);
  wire         sync_w = cmr_ff[`UBRG_CMR_SYNC];
  wire         over_w = cmr_ff[`UBRG_CMR_OVER];
  wire         clock_output_enable_w = cmr_ff[`UBRG_CMR_CLOCK_OUTPUT_ENABLE];
  wire         wake_w = cmr_ff[`UBRG_CMR_WAKE];
  wire [DW-1:0] div_w = bdr_ff[`UBRG_BDR_DIV_LSB +: DW];
  wire  [2:0]  frac_w = bdr_ff[`UBRG_BDR_FRAC_LSB +: 3];

  // status word
  logic        run_w;
  wire  [31:0] str_w  = {16'h0000, bcnt_ff, 5'h00, samp_clk_o, clk_req_o, run_w};

  // read mux, unmapped reads as zero
  wire  [31:0] rmux_w = hit_wmr ? wmr_ff :
                        hit_cmr ? cmr_ff :
                        hit_bdr ? bdr_ff :
                        hit_str ? str_w  : 32'h0000_0000;

  // register writes and single-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wmr_ff  <= `UBRG_WMR_RST;
      cmr_ff  <= `UBRG_CMR_RST;
      bdr_ff  <= `UBRG_BDR_RST;
      rdat_ff <= 32'h0000_0000;
      ack_ff  <= 1'b0;
    end else begin
      ack_ff  <= req_w;
      rdat_ff <= req_w ? rmux_w : 32'h0000_0000;
      if (wr_w && hit_wmr) wmr_ff <= nxt_wmr;
      if (wr_w && hit_cmr) cmr_ff <= nxt_cmr;
      if (wr_w && hit_bdr) bdr_ff <= nxt_bdr;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  // ********************************
  // source synchronisers
  // ********************************
  logic [2:0] pck_sy_ff;
  logic [2:0] sck_sy_ff;
  logic [1:0] rxd_sy_ff;

  // two stages, third only for edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pck_sy_ff <= 3'h0;
      sck_sy_ff <= 3'h0;
      rxd_sy_ff <= 2'h3;
    end else begin
      pck_sy_ff <= {pck_sy_ff[1:0], pck_i};
      sck_sy_ff <= {sck_sy_ff[1:0], sck_i};
      rxd_sy_ff <= {rxd_sy_ff[0], rxd_i};
    end
  end

  // rising edges seen after the second stage
  wire pck_rise = pck_sy_ff[1] && !pck_sy_ff[2];
  wire sck_rise = sck_sy_ff[1] && !sck_sy_ff[2];
  wire rxd_low  = !rxd_sy_ff[1];

  // ********************************
  // clock source selection
  // ********************************
  logic [2:0] fdc_ff;
  wire        fix_tick = (fdc_ff == 3'(`UBRG_FIX_DIV - 1));

  // fixed divide of the peripheral clock, held while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fdc_ff <= 3'h0;
    end else if (run_en) begin
      fdc_ff <= fdc_ff + 3'h1;
    end
  end

  // source enable, gated by operating mode
  logic src_raw;
  always_comb begin
    src_raw = 1'b0;
    unique case (css_w)
      UBRG_SRC_PER: src_raw = 1'b1;
      UBRG_SRC_DIV: src_raw = fix_tick;
      UBRG_SRC_PCK: src_raw = pck_rise;
      UBRG_SRC_EXT: src_raw = sck_rise;
    endcase
  end
  wire src_tick = run_en && src_raw;

  // ********************************
  // divider core
  // ********************************
  logic samp_w;
  logic phase_w;

  ubrg_div #(
    .DW      (DW)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (src_tick),
    .div_i   (div_w),
    .frac_i  (frac_w),
    .samp_o  (samp_w),
    .phase_o (phase_w),
    .run_o   (run_w)
  );

  assign samp_en_o  = samp_w;
  assign samp_clk_o = phase_w;

  // ********************************
  // oversampling divide
  // ********************************
  logic [3:0] ovs_ff;
  logic       baud_ff;
  wire  [3:0] lim_w  = over_w ? 4'(`UBRG_OVS_LO - 1) : 4'(`UBRG_OVS_HI - 1);
  wire        wrap_w = (ovs_ff >= lim_w);

  // bit-period enable from sampling enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovs_ff  <= 4'h0;
      baud_ff <= 1'b0;
      bcnt_ff <= 8'h00;
    end else begin
      baud_ff <= samp_w && (sync_w || wrap_w);
      if (samp_w && (sync_w || wrap_w)) begin
        ovs_ff  <= 4'h0;
        bcnt_ff <= bcnt_ff + 8'h01;
      end else if (samp_w) begin
        ovs_ff  <= ovs_ff + 4'h1;
      end
    end
  end

  assign baud_en_o = baud_ff;

  // ********************************
  // pin drive, interrupt, clock request
  // ********************************
  logic sck_ff;
  logic sck_oe_ff;
  logic irq_ff;
  logic req_ff;

  // outputs registered toward pin, interrupt controller and power manager
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_ff    <= 1'b0;
      sck_oe_ff <= 1'b0;
      irq_ff    <= 1'b0;
      req_ff    <= 1'b0;
    end else begin
      sck_ff    <= phase_w;
      sck_oe_ff <= clock_output_enable_w && (css_w != UBRG_SRC_EXT) && run_en;
      irq_ff    <= chan_irq_i && run_en;
      req_ff    <= wake_w && (rxd_low || run_w);
    end
  end

  assign sck_o     = sck_ff;
  assign sck_oe_o  = sck_oe_ff;
  assign irq_o     = irq_ff;
  assign clk_req_o = req_ff;

  // ********************************
  // checks
  // ********************************
  a_mode_stops_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run_en) [*3] |-> !samp_en_o && !src_tick)
    else $error("sampling enable while channel stopped");
  a_irq_shared: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == ($past(chan_irq_i) && $past(run_en)))
    else $error("interrupt not shared per operating mode");
  a_fixed_eighth: assert property (@(posedge clk_i) disable iff (rst_i)
    (fix_tick && run_en) [*1] ##1 run_en [*7] |=> fix_tick)
    else $error("fixed divide not by eight");
  a_ovs_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en_o && !sync_w && wrap_w) |=> baud_en_o && ovs_ff == 4'h0)
    else $error("bit period not ended at oversample limit");
  a_ovs_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en_o && !sync_w && !wrap_w) |=> !baud_en_o)
    else $error("bit period ended early");
  a_sync_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_en_o && sync_w) |=> baud_en_o)
    else $error("synchronous bit clock not direct");
  a_baud_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    baud_en_o |-> $past(samp_en_o))
    else $error("bit enable without sampling enable");
  a_wake_request: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_w && rxd_low) |=> clk_req_o)
    else $error("no clock request on wakeup activity");
  a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
endmodule

// file: hw/ubrg_defs.svh
// register offsets, field positions, reset values and counts of the baud generator
`ifndef UBRG_DEFS_SVH
`define UBRG_DEFS_SVH

// ********************************
// register offsets (byte addresses)
// ********************************
`define UBRG_OFS_WMR 8'h00
`define UBRG_OFS_CMR 8'h04
`define UBRG_OFS_BDR 8'h08
`define UBRG_OFS_STR 8'h0C

// ********************************
// reset values and writable bits
// ********************************
`define UBRG_WMR_RST  32'h0000_0000
`define UBRG_CMR_RST  32'h0000_0000
`define UBRG_BDR_RST  32'h0000_0000
`define UBRG_WMR_MASK 32'h0000_0003
`define UBRG_CMR_MASK 32'h0000_0FF3
`define UBRG_BDR_MASK 32'h0007_FFFF

// ********************************
// field positions
// ********************************
`define UBRG_CMR_CSS_LSB  0
`define UBRG_CMR_SYNC     4
`define UBRG_CMR_OVER     5
`define UBRG_CMR_CLOCK_OUTPUT_ENABLE     6
`define UBRG_CMR_WAKE     7
`define UBRG_CMR_MODE_LSB 8
`define UBRG_BDR_DIV_LSB  0
`define UBRG_BDR_FRAC_LSB 16

// ********************************
// codes and counts
// ********************************
`define UBRG_OPM_CHAN 2'h1
`define UBRG_FIX_DIV  8
`define UBRG_OVS_LO   8
`define UBRG_OVS_HI   16

`endif

// file: hw/ubrg_pkg.sv
// types shared by the baud generator modules
package ubrg_pkg;

  // clock source of the divider
  typedef enum logic [1:0] {
    UBRG_SRC_PER = 2'b00,
    UBRG_SRC_DIV = 2'b01,
    UBRG_SRC_PCK = 2'b10,
    UBRG_SRC_EXT = 2'b11
  } ubrg_src_type;

  // state of the divider core
  typedef enum logic [1:0] {
    UBRG_ST_IDLE = 2'b00,
    UBRG_ST_RUN  = 2'b01,
    UBRG_ST_EXT  = 2'b10
  } ubrg_state_type;

endpackage

// file: hw/ubrg_div.sv
// divider core: reloading down-counter with eighth-step fraction
`timescale 1ns/1ps
module ubrg_div #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // selected clock enable and settings
  input  wire logic          tick_i,
  input  wire logic [DW-1:0] div_i,
  input  wire logic [2:0]    frac_i,
  // sampling enable and clock level
  output logic               samp_o,
  output logic               phase_o,
  output logic               run_o
);
  import ubrg_pkg::*;

  ubrg_state_type st_ff;
  ubrg_state_type nxt_st;
  logic [DW-1:0]  cnt_ff;
  logic [DW-1:0]  cur_ff;
  logic [2:0]     acc_ff;
  logic           extra_ff;
  logic           samp_ff;
  logic           phase_ff;

  // ********************************
  // reload decode
  // ********************************
  wire  last_w   = (st_ff == UBRG_ST_RUN) && (cnt_ff == DW'(1));
  wire  reload_w = tick_i && ((last_w && !extra_ff) || (st_ff == UBRG_ST_EXT));
  wire  start_w  = (st_ff == UBRG_ST_IDLE) && (div_i != '0);
  wire  [3:0] sum_w = {1'b0, acc_ff} + {1'b0, frac_i};
  wire  hi_w     = (cnt_ff > (cur_ff >> 1)) || (st_ff == UBRG_ST_EXT);

  // next state
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      UBRG_ST_IDLE: if (start_w) nxt_st = UBRG_ST_RUN;
      UBRG_ST_RUN: begin
        if (tick_i && last_w && extra_ff) nxt_st = UBRG_ST_EXT;
        else if (reload_w && div_i == '0) nxt_st = UBRG_ST_IDLE;
      end
      UBRG_ST_EXT: begin
        if (reload_w) nxt_st = (div_i == '0) ? UBRG_ST_IDLE : UBRG_ST_RUN;
      end
      default: nxt_st = UBRG_ST_IDLE;
    endcase
  end

  // counter, latched settings and fraction accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff    <= UBRG_ST_IDLE;
      cnt_ff   <= '0;
      cur_ff   <= '0;
      acc_ff   <= 3'h0;
      extra_ff <= 1'b0;
      samp_ff  <= 1'b0;
      phase_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      samp_ff  <= reload_w;
      phase_ff <= (st_ff != UBRG_ST_IDLE) && hi_w;
      if (start_w || reload_w) begin
        cnt_ff   <= div_i;
        cur_ff   <= div_i;
        acc_ff   <= start_w ? frac_i : sum_w[2:0];
        extra_ff <= start_w ? 1'b0 : sum_w[3];
      end else if (tick_i && st_ff == UBRG_ST_RUN && !last_w) begin
        cnt_ff <= cnt_ff - DW'(1);
      end
    end
  end

  assign samp_o  = samp_ff;
  assign phase_o = phase_ff;
  assign run_o   = (st_ff != UBRG_ST_IDLE);

  // ********************************
  // checks
  // ********************************
  a_zero_div_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == UBRG_ST_IDLE && div_i == '0) [*2] |-> !samp_o)
    else $error("sampling enable with zero divisor");
  a_bypass_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (last_w && cur_ff == DW'(1) && !extra_ff && tick_i) |=> samp_o)
    else $error("divisor one does not pass the clock");
  a_stretch_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == UBRG_ST_EXT && tick_i) |=> samp_o && phase_o)
    else $error("stretched cycle did not end the period");
  a_frac_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (reload_w && frac_i == 3'h0 && acc_ff == 3'h0) |=> !extra_ff)
    else $error("extra cycle without fraction");
  a_hold_setting: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == UBRG_ST_RUN && !reload_w) |=> $stable(cur_ff))
    else $error("divisor changed inside a period");
endmodule

// file: verif/ubrg_far.sv
// partner model: programmable clock of the power manager and external pin clock
`timescale 1ns/1ps
module ubrg_far #(
  parameter int PCK_HALF = 3,
  parameter int SCK_HALF = 4
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin clock gate
  input  wire logic run_i,
  // generated clocks
  output logic      pck_o,
  output logic      sck_o
);
  logic [7:0] pck_cnt_ff;
  logic [7:0] sck_cnt_ff;
  wire        pck_wrap = (pck_cnt_ff == 8'(PCK_HALF - 1));
  wire        sck_wrap = (sck_cnt_ff == 8'(SCK_HALF - 1));
  // programmable clock, free running, far slower than clk_i
  always_ff @(posedge clk_i) begin
    pck_cnt_ff <= (rst_i || pck_wrap) ? 8'h00 : pck_cnt_ff + 8'h01;
    pck_o      <= rst_i ? 1'b0 : pck_o ^ pck_wrap;
  end
  // pin clock runs only while enabled, idles low, phases of several cycles
  always_ff @(posedge clk_i) begin
    sck_cnt_ff <= (rst_i || !run_i || sck_wrap) ? 8'h00 : sck_cnt_ff + 8'h01;
    sck_o      <= (rst_i || !run_i) ? 1'b0 : sck_o ^ sck_wrap;
  end
endmodule

// file: verif/ubrg_top_test.sv
// testbench of the baud rate generator: register access and clock enables
`timescale 1ns/1ps
module ubrg_top_test;
  import ubrg_pkg::*;
  localparam int PH = 3;
  localparam int SH = 4;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, rxd_i, chan_irq_i, run_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        ack_o, pck_i, far_sck, sck_o, sck_oe_o, irq_o, clk_req_o, samp_en_o, baud_en_o, samp_clk_o;
  wire         sck_pin = sck_oe_o ? sck_o : far_sck;
  int          n_fail = 0, total_checks = 0, wd = 0, cy, nb, nh, ns, no;

  ubrg_top i_ubrg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pck_i(pck_i), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .rxd_i(rxd_i), .chan_irq_i(chan_irq_i), .irq_o(irq_o), .clk_req_o(clk_req_o),
    .samp_en_o(samp_en_o), .baud_en_o(baud_en_o), .samp_clk_o(samp_clk_o));
  ubrg_far #(.PCK_HALF(PH), .SCK_HALF(SH)) i_ubrg_far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_i),
    .pck_o(pck_i), .sck_o(far_sck));

  // ********************************
  // clock, watchdog and helpers
  // ********************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    wd = wd + 1;
    if (wd == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task close_out;
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      #1;
    end while (ack_o !== 1'b1);
    q = dat_o;
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  function automatic logic [31:0] cmr(input logic [1:0] s, input logic ov, input logic sy, input logic ck,
                                      input logic wk);
    return {24'h00_0000, wk, ck, ov, sy, 2'b00, s};
  endfunction
  // skip two pulses, then count cycles, bit pulses and high cycles over n periods
  task gap(input int n);
    int k;
    k  = 0;
    cy = 0;
    nb = 0;
    nh = 0;
    no = 0;
    repeat (2) begin
      do begin
        @(posedge clk_i);
        #1;
      end while (samp_en_o !== 1'b1);
    end
    while (k < n) begin
      @(posedge clk_i);
      #1;
      cy++;
      if (samp_clk_o === 1'b1) nh++;
      if (sck_o === 1'b1) no++;
      if (samp_en_o === 1'b1) k++;
      if (baud_en_o === 1'b1) nb++;
    end
  endtask
  task quiet(input int n);
    ns = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (samp_en_o !== 1'b0 || baud_en_o !== 1'b0) ns++;
    end
  endtask

  // ********************************
  // test sequence
  // ********************************
  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'hF;
    dat_i = 32'h0000_0000; rxd_i = 1'b1; chan_irq_i = 1'b0; run_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0000_0000, "wrapper mode reset");
    rd(8'h04, 32'h0000_0000, "channel mode reset");
    rd(8'h08, 32'h0000_0000, "divisor reset");
    wb(1'b1, 8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_0FF3, "channel mode bits");
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000, "unmapped");
    wb(1'b1, 8'h04, cmr(2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
    wb(1'b1, 8'h08, 32'h0000_0002);
    chan_irq_i <= 1'b1;
    quiet(40);
    chk("pulses mode stopped", 32'd0, ns);
    chk("irq mode stopped", 32'd0, irq_o);
    wb(1'b1, 8'h00, 32'h0000_0001);
    gap(32);
    chk("div2 cycles", 32'd64, cy);
    chk("div2 bits x16", 32'd2, nb);
    chk("div2 high", 32'd32, nh);
    chk("irq mode one", 32'd1, irq_o);
    wb(1'b1, 8'h04, cmr(2'd0, 1'b1, 1'b0, 1'b0, 1'b0));
    gap(32);
    chk("bits x8", 32'd4, nb);
    wb(1'b1, 8'h04, cmr(2'd0, 1'b0, 1'b1, 1'b0, 1'b0));
    gap(32);
    chk("sync bits", 32'd32, nb);
    wb(1'b1, 8'h04, cmr(2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
    wb(1'b1, 8'h08, 32'h0000_0001);
    gap(16);
    chk("bypass cycles", 32'd16, cy);
    wb(1'b1, 8'h04, cmr(2'd1, 1'b0, 1'b0, 1'b0, 1'b0));
    gap(4);
    chk("fixed eighth", 32'd32, cy);
    wb(1'b1, 8'h08, 32'h0000_0002);
    wb(1'b1, 8'h04, cmr(2'd2, 1'b0, 1'b0, 1'b1, 1'b0));
    gap(4);
    chk("programmable", 32'(8 * 2 * PH), cy);
    chk("pin drive enable", 32'd1, sck_oe_o);
    chk("pin drive high", 32'(4 * 2 * PH), no);
    run_i <= 1'b1;
    wb(1'b1, 8'h04, cmr(2'd3, 1'b0, 1'b0, 1'b0, 1'b0));
    wb(1'b1, 8'h08, 32'h0000_0001);
    gap(4);
    chk("pin clock", 32'(4 * 2 * SH), cy);
    chk("pin drive off", 32'd0, sck_oe_o);
    wb(1'b1, 8'h04, cmr(2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
    run_i <= 1'b0;
    wb(1'b1, 8'h08, 32'h0004_0002);
    gap(8);
    chk("fraction cycles", 32'd20, cy);
    chk("fraction high", 32'd12, nh);
    wb(1'b1, 8'h08, 32'h0000_0008);
    gap(2);
    wb(1'b1, 8'h08, 32'h0000_0002);
    cy = 3;
    #1;
    while (samp_en_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      cy++;
    end
    chk("period kept", 32'd8, cy);
    gap(4);
    chk("new divisor", 32'd8, cy);
    wb(1'b1, 8'h08, 32'h0000_0000);
    repeat (20) @(posedge clk_i);
    quiet(40);
    chk("zero divisor", 32'd0, ns);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk("status idle", 32'h0000_0000, {29'h0, q[2:0]});
    wb(1'b1, 8'h04, cmr(2'd0, 1'b0, 1'b0, 1'b0, 1'b1));
    repeat (6) @(posedge clk_i);
    #1;
    chk("request idle line", 32'd0, clk_req_o);
    @(posedge clk_i);
    rxd_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk("request on activity", 32'd1, clk_req_o);
    wb(1'b1, 8'h04, cmr(2'd0, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (3) @(posedge clk_i);
    #1;
    chk("request wake off", 32'd0, clk_req_o);
    close_out();
  end
endmodule
